// File: hdl/psar_mdio_slave.sv
// Purpose: Management frame engine, samples mdc and mdio in the clk domain
// Assumes: mdc slower than clk by at least eight to one
// Notes:   Read data is driven after each mdc rising edge
`timescale 1ns/1ns
module psar_mdio_slave
  import psar_pkg::*;
(
  input  wire logic        clk,       // System clock
  input  wire logic        srst,      // Synchronous reset
  input  wire logic        mdc_lvl,   // Filtered management clock
  input  wire logic        mdio_lvl,  // Filtered management data
  input  wire logic [4:0]  phy_addr,  // Port address
  input  wire logic [15:0] rd_data,   // Word for the addressed register
  output logic      [4:0]  reg_addr,  // Register address of frame
  output logic             rd_take,   // Read word captured, one cycle
  output logic             wr_stb,    // Write pulse
  output logic      [15:0] wr_data,   // Write data
  output logic             mdio_out,  // Data pin output
  output logic             mdio_oe    // Data pin enable
);
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_HDR, S_TA_RD, S_RD, S_WR, S_SKIP
  } psar_mdio_state_t;

  typedef struct packed {
    psar_mdio_state_t st;
    logic             mdc_prev;
    logic [4:0]       cnt;
    logic [15:0]      sh;
    logic [4:0]       addr;
    logic [15:0]      out_sh;
    logic             mdio_o;
    logic             oe;
    logic             wr_stb;
  } psar_mdio_t;

  psar_mdio_t  fr_q;
  psar_mdio_t  fr_d;
  logic        rise;
  logic [15:0] nsh;

  always_comb begin
    fr_d          = fr_q;
    fr_d.wr_stb   = 1'b0;
    fr_d.mdc_prev = mdc_lvl;
    rise          = mdc_lvl & ~fr_q.mdc_prev;
    nsh           = {fr_q.sh[14:0], mdio_lvl};
    rd_take       = 1'b0;
    if (rise) begin
      case (fr_q.st)
        S_IDLE: begin
          // Idle ones are optional, so a single zero opens a frame
          if (!mdio_lvl) fr_d.st = S_START;
        end
        S_START: begin
          fr_d.cnt = 5'h00;
          fr_d.st  = mdio_lvl ? S_HDR : S_IDLE;
        end
        S_HDR: begin
          fr_d.sh  = nsh;
          fr_d.cnt = fr_q.cnt + 5'h01;
          if (fr_q.cnt == HDR_LAST) begin
            fr_d.addr = nsh[4:0];
            fr_d.cnt  = 5'h00;
            if (nsh[9:5] != phy_addr) fr_d.st = S_SKIP;
            else if (nsh[11:10] == OP_READ) fr_d.st = S_TA_RD;
            else if (nsh[11:10] == OP_WRITE) fr_d.st = S_WR;
            else fr_d.st = S_SKIP;
          end
        end
        S_TA_RD: begin
          rd_take     = 1'b1;
          fr_d.out_sh = rd_data;
          fr_d.oe     = 1'b1;
          fr_d.mdio_o = 1'b0;
          fr_d.st     = S_RD;
        end
        S_RD: begin
          if (fr_q.cnt == DATA_BITS) begin
            fr_d.oe = 1'b0;
            fr_d.st = S_IDLE;
          end else begin
            fr_d.mdio_o = fr_q.out_sh[15];
            fr_d.out_sh = {fr_q.out_sh[14:0], 1'b0};
            fr_d.cnt    = fr_q.cnt + 5'h01;
          end
        end
        S_WR: begin
          fr_d.sh  = nsh;
          fr_d.cnt = fr_q.cnt + 5'h01;
          if (fr_q.cnt == WR_LAST) begin
            fr_d.wr_stb = 1'b1;
            fr_d.st     = S_IDLE;
          end
        end
        S_SKIP: begin
          fr_d.cnt = fr_q.cnt + 5'h01;
          if (fr_q.cnt == WR_LAST) fr_d.st = S_IDLE;
        end
        default: fr_d.st = S_IDLE;
      endcase
    end
    if (srst) begin
      fr_d          = '0;
      fr_d.st       = S_IDLE;
      fr_d.mdc_prev = 1'b1;
      rd_take       = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    fr_q <= fr_d;
  end

  assign reg_addr = fr_q.addr;
  assign wr_stb   = fr_q.wr_stb;
  assign wr_data  = fr_q.sh;
  assign mdio_out = fr_q.mdio_o;
  assign mdio_oe  = fr_q.oe;
endmodule : psar_mdio_slave

// File: hdl/psar_pkg.sv
// Purpose: Shared constants for the PHY status, identity and negotiation register bank
// Assumes: Clause 22 style management frames, 16-bit registers
// Notes:   Offsets are management register addresses, not byte addresses
package psar_pkg;
  // Register addresses
  localparam logic [4:0]  REG_MODE_STATUS = 5'h01;
  localparam logic [4:0]  REG_ID_HIGH     = 5'h02;
  localparam logic [4:0]  REG_ID_LOW      = 5'h03;
  localparam logic [4:0]  REG_ADVERT      = 5'h04;
  localparam logic [4:0]  REG_PARTNER     = 5'h05;
  localparam logic [4:0]  REG_EXPANSION   = 5'h06;
  // Mode status: fixed bits, live bits cleared here
  localparam logic [15:0] STATUS_FIXED    = 16'h7949;
  localparam int          ST_AN_DONE      = 5;
  localparam int          ST_FAR_FAULT    = 4;
  localparam int          ST_LINK         = 2;
  localparam int          ST_JABBER       = 1;
  // Advertisement layout and reset
  localparam logic [15:0] ADV_WR_MASK     = 16'hbfff;
  localparam logic [15:0] ADV_RESET       = 16'h0001;
  localparam logic [15:0] PARTNER_MASK    = 16'hefff;
  // Expansion bits
  localparam int          EXP_PD_FAULT    = 4;
  localparam int          EXP_LINK_PARTNER_NP = 3;
  localparam int          EXP_LOCAL_NP    = 2;
  localparam int          EXP_PAGE_RX     = 1;
  localparam int          EXP_LINK_PARTNER_AN = 0;
  // Management frame
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_WRITE        = 2'h1;
  localparam logic [4:0]  HDR_LAST        = 5'h0b;
  localparam logic [4:0]  DATA_BITS       = 5'h10;
  localparam logic [4:0]  WR_LAST         = 5'h11;
  // Synchroniser lanes
  localparam int          SYNC_W          = 8;
  localparam int          SYNC_MDC        = 0;
  localparam int          SYNC_MDIO       = 1;
  localparam int          SYNC_STRAP      = 2;
endpackage : psar_pkg

// File: hdl/psar_regs.sv
// Purpose: Status, identity and negotiation registers of one copper port
// Assumes: Status inputs come from logic on clk; pins are asynchronous
// Notes:   Hold srst for at least five clk edges so the straps settle
`timescale 1ns/1ns

module psar_regs
  import psar_pkg::*;
#(
  parameter logic [15:0] ID_OUI_HIGH = 16'h2a5c,  // Arbitrary value
  parameter logic [5:0]  ID_OUI_LOW  = 6'h15,     // Arbitrary value
  parameter logic [5:0]  ID_MODEL    = 6'h0c,     // Arbitrary value
  parameter logic [3:0]  ID_REV      = 4'h2       // Arbitrary value
)
(
  input  wire logic        clk,                   // 25 MHz clock
  input  wire logic        srst,                  // Synchronous reset
  input  wire logic        mdc,                   // Management clock pin
  input  wire logic        mdio_in,               // Management data in
  output logic             mdio_out,              // Management data out
  output logic             mdio_oe,               // Management data enable
  input  wire logic [4:0]  phy_addr,              // Port address, static
  input  wire logic [5:0]  config_strap_default,  // Advertise straps
  input  wire logic        an_complete,           // Negotiation done
  input  wire logic        far_fault,             // Far-end fault seen
  input  wire logic        link_up,               // Link is up
  input  wire logic        jabber,                // Jabber seen
  input  wire logic [15:0] link_partner_page,     // Partner base page
  input  wire logic        link_partner_page_valid, // Base page load pulse
  input  wire logic        parallel_fault,        // Parallel detect fault
  input  wire logic        link_partner_np_able,  // Partner next-page able
  input  wire logic        page_received,         // New page pulse
  input  wire logic        link_partner_an_able,  // Partner can negotiate
  output logic      [15:0] advertisement          // Local advertisement
);
  typedef struct packed {
    logic        an_done;
    logic        far_fault;
    logic        link;
    logic        jabber;
    logic        pd_fault;
    logic        page_rx;
    logic        link_partner_np;
    logic        link_partner_an;
    logic [15:0] partner;
    logic [15:0] adv;
  } psar_regs_t;

  psar_regs_t        rg_q;
  psar_regs_t        rg_d;
  logic [SYNC_W-1:0] pin_lvl;
  logic [5:0]        strap_lvl;
  logic [4:0]        reg_addr;
  logic              rd_take;
  logic              wr_stb;
  logic [15:0]       wr_data;
  logic [15:0]       rd_word;
  logic [15:0]       status_word;
  logic [15:0]       exp_word;
  logic              stat_read;
  logic              exp_read;

  psar_sync u_sync (
    .clk  (clk),
    .din  ({config_strap_default, mdio_in, mdc}),
    .dout (pin_lvl)
  );

  assign strap_lvl = pin_lvl[SYNC_STRAP +: 6];

  psar_mdio_slave u_mdio (
    .clk      (clk),
    .srst     (srst),
    .mdc_lvl  (pin_lvl[SYNC_MDC]),
    .mdio_lvl (pin_lvl[SYNC_MDIO]),
    .phy_addr (phy_addr),
    .rd_data  (rd_word),
    .reg_addr (reg_addr),
    .rd_take  (rd_take),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe)
  );

  assign stat_read = rd_take && (reg_addr == REG_MODE_STATUS);
  assign exp_read  = rd_take && (reg_addr == REG_EXPANSION);

  always_comb begin
    status_word               = STATUS_FIXED;
    status_word[ST_AN_DONE]   = rg_q.an_done;
    status_word[ST_FAR_FAULT] = rg_q.far_fault;
    status_word[ST_LINK]      = rg_q.link;
    status_word[ST_JABBER]    = rg_q.jabber;
    exp_word                  = 16'h0000;
    exp_word[EXP_PD_FAULT]    = rg_q.pd_fault;
    exp_word[EXP_LINK_PARTNER_NP] = rg_q.link_partner_np;
    exp_word[EXP_LOCAL_NP]    = 1'b1;
    exp_word[EXP_PAGE_RX]     = rg_q.page_rx;
    exp_word[EXP_LINK_PARTNER_AN] = rg_q.link_partner_an;
  end

  // Unmapped addresses, including mode control, read as zero
  always_comb begin
    if (reg_addr == REG_MODE_STATUS) begin
      rd_word = status_word;
    end else if (reg_addr == REG_ID_HIGH) begin
      rd_word = ID_OUI_HIGH;
    end else if (reg_addr == REG_ID_LOW) begin
      rd_word = {ID_OUI_LOW, ID_MODEL, ID_REV};
    end else if (reg_addr == REG_ADVERT) begin
      rd_word = rg_q.adv;
    end else if (reg_addr == REG_PARTNER) begin
      rd_word = rg_q.partner;
    end else if (reg_addr == REG_EXPANSION) begin
      rd_word = exp_word;
    end else begin
      rd_word = 16'h0000;
    end
  end

  always_comb begin
    rg_d         = rg_q;
    rg_d.an_done = an_complete;
    rg_d.link_partner_np = link_partner_np_able;
    rg_d.link_partner_an = link_partner_an_able;
    // The read captures the old latch value in the same cycle that the
    // latch reloads from the live input, so no event slips between them
    rg_d.far_fault = stat_read ? far_fault : (rg_q.far_fault | far_fault);
    rg_d.jabber    = stat_read ? jabber : (rg_q.jabber | jabber);
    rg_d.link      = stat_read ? link_up : (rg_q.link & link_up);
    rg_d.pd_fault  = exp_read ? parallel_fault
                              : (rg_q.pd_fault | parallel_fault);
    rg_d.page_rx   = exp_read ? page_received
                              : (rg_q.page_rx | page_received);
    if (link_partner_page_valid) begin
      rg_d.partner = link_partner_page & PARTNER_MASK;
    end
    // Only the advertisement word takes writes; all else ignores them
    if (wr_stb && (reg_addr == REG_ADVERT)) begin
      rg_d.adv = wr_data & ADV_WR_MASK;
    end
    if (srst) begin
      rg_d          = '0;
      rg_d.adv      = ADV_RESET;
      rg_d.adv[11:10] = strap_lvl[5:4];
      rg_d.adv[8:5] = strap_lvl[3:0];
    end
  end

  always_ff @(posedge clk) begin
    rg_q <= rg_d;
  end

  assign advertisement = rg_q.adv;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_no_stat_read;
    (!stat_read) [*4];
  endsequence

  sequence s_no_exp_read;
    (!exp_read) [*4];
  endsequence

  a_caps_fixed_ones: assert property (status_word[14:11] == 4'hf)
    else $error("capability ones missing");
  a_caps_fixed_zeros: assert property (
    !status_word[15] && (status_word[10:9] == 2'h0))
    else $error("absent capability reads one");
  a_ext_status_bit: assert property (status_word[8])
    else $error("extended status bit low");
  a_preamble_opt_bit: assert property (status_word[6])
    else $error("preamble suppression bit low");
  a_an_done_tracks: assert property (
    !$past(srst) |-> (status_word[ST_AN_DONE] == $past(an_complete)))
    else $error("negotiation complete bit wrong");
  a_an_done_reset: assert property (
    $fell(srst) |-> !status_word[ST_AN_DONE])
    else $error("negotiation complete set after reset");
  a_far_fault_held: assert property (
    far_fault ##1 s_no_stat_read |-> status_word[ST_FAR_FAULT])
    else $error("far-end fault not held");
  a_an_able_bit: assert property (status_word[3])
    else $error("negotiation ability bit low");
  a_link_drop_held: assert property (
    !link_up ##1 s_no_stat_read |-> !status_word[ST_LINK])
    else $error("link dropout not held");
  a_jabber_held: assert property (
    jabber ##1 s_no_stat_read |-> status_word[ST_JABBER])
    else $error("jabber not held");
  a_ext_cap_bits: assert property (
    status_word[0] && !status_word[7])
    else $error("extended capability or reserved bit wrong");
  a_id_high_value: assert property (
    (rd_take && reg_addr == REG_ID_HIGH) |-> (rd_word == ID_OUI_HIGH))
    else $error("identifier high word wrong");
  a_id_low_value: assert property (
    (rd_take && reg_addr == REG_ID_LOW) |->
      (rd_word == {ID_OUI_LOW, ID_MODEL, ID_REV}))
    else $error("identifier low word wrong");
  a_pause_strap_reset: assert property (
    $fell(srst) |-> (advertisement[11:10] == $past(strap_lvl[5:4])))
    else $error("pause bits not taken from straps");
  a_pause_write: assert property (
    (wr_stb && reg_addr == REG_ADVERT) |=>
      (advertisement[11:10] == $past(wr_data[11:10])))
    else $error("pause bits not written");
  a_tech_strap_reset: assert property (
    $fell(srst) |-> (!advertisement[9] &&
      (advertisement[8:5] == $past(strap_lvl[3:0]))))
    else $error("technology bits reset wrong");
  a_tech_write: assert property (
    (wr_stb && reg_addr == REG_ADVERT) |=>
      (advertisement[9:5] == $past(wr_data[9:5])))
    else $error("technology bits not written");
  a_partner_pause: assert property (
    link_partner_page_valid |=>
      (rg_q.partner[11:10] == $past(link_partner_page[11:10])))
    else $error("partner pause bits not loaded");
  a_partner_ro: assert property (
    (wr_stb && reg_addr == REG_PARTNER && !link_partner_page_valid) |=>
      $stable(rg_q.partner))
    else $error("partner word changed by write");
  a_pd_fault_held: assert property (
    parallel_fault ##1 s_no_exp_read |->
      (exp_word[EXP_PD_FAULT] && (exp_word[15:5] == 11'h000)))
    else $error("parallel fault not held");
  a_partner_np_tracks: assert property (
    !$past(srst) |->
      (exp_word[EXP_LINK_PARTNER_NP] == $past(link_partner_np_able)))
    else $error("partner next-page bit wrong");
  a_local_np_bit: assert property (exp_word[EXP_LOCAL_NP])
    else $error("local next-page bit low");
  a_page_rx_held: assert property (
    page_received ##1 s_no_exp_read |-> exp_word[EXP_PAGE_RX])
    else $error("received page not held");
  a_partner_an_tracks: assert property (
    !$past(srst) |->
      (exp_word[EXP_LINK_PARTNER_AN] == $past(link_partner_an_able)))
    else $error("partner negotiation bit wrong");
  a_read_relive: assert property (
    (stat_read && link_up && !far_fault) ##1 (link_up && !far_fault) |->
      (status_word[ST_LINK] && !status_word[ST_FAR_FAULT]))
    else $error("latched bits not returned to live");

  // First edge after reset release
  sequence s_reset_done;
    $fell(srst);
  endsequence

  sequence s_adv_write;
    wr_stb && (reg_addr == REG_ADVERT);
  endsequence

  // Reset values: latches clear, only fixed bits remain
  a_status_reset: assert property (
    s_reset_done |-> (status_word == STATUS_FIXED))
    else $error("status word wrong after reset");
  a_exp_reset: assert property (
    s_reset_done |-> (exp_word == 16'h0004))
    else $error("expansion word wrong after reset");
  a_partner_reset: assert property (
    s_reset_done |-> (rg_q.partner == 16'h0000))
    else $error("partner word not cleared by reset");

  // Partner word only moves on a base page load
  a_partner_hold: assert property (
    !link_partner_page_valid |=> $stable(rg_q.partner))
    else $error("partner word changed without load");
  a_partner_reserved: assert property (
    rg_q.partner[12] == 1'b0)
    else $error("partner reserved bit set");

  // Writes reach only the advertisement word, minus its reserved bit
  a_adv_other_write: assert property (
    (wr_stb && reg_addr != REG_ADVERT) |=> $stable(advertisement))
    else $error("advertisement changed by foreign write");
  a_adv_write_word: assert property (
    s_adv_write |=> (advertisement == ($past(wr_data) & ADV_WR_MASK)))
    else $error("advertisement write wrong");
  a_adv_reserved: assert property (
    advertisement[14] == 1'b0)
    else $error("advertisement reserved bit set");

  // A read re-arms latches from the live inputs
  a_stat_word_read: assert property (
    stat_read |-> (rd_word == status_word))
    else $error("status read word differs");
  a_link_relive: assert property (
    (stat_read && link_up) |=> status_word[ST_LINK])
    else $error("link bit not re-armed by read");
  a_jabber_relive: assert property (
    (stat_read && !jabber) |=> !status_word[ST_JABBER])
    else $error("jabber bit not cleared by read");
  a_pd_relive: assert property (
    (exp_read && !parallel_fault) |=> !exp_word[EXP_PD_FAULT])
    else $error("parallel fault not cleared by read");
  a_page_rx_relive: assert property (
    (exp_read && !page_received) |=> !exp_word[EXP_PAGE_RX])
    else $error("received page not cleared by read");

  // An event in the reading cycle must not be lost
  a_far_set_wins: assert property (
    (stat_read && far_fault) |=> status_word[ST_FAR_FAULT])
    else $error("far-end fault lost on read");
  a_jabber_set_wins: assert property (
    (stat_read && jabber) |=> status_word[ST_JABBER])
    else $error("jabber lost on read");
  a_page_set_wins: assert property (
    (exp_read && page_received) |=> exp_word[EXP_PAGE_RX])
    else $error("received page lost on read");
  a_exp_reserved: assert property (
    exp_word[15:5] == 11'h000)
    else $error("expansion reserved bits set");
endmodule : psar_regs

// File: hdl/psar_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes:   No reset; outputs settle four edges after clk starts
`timescale 1ns/1ns
module psar_sync
  import psar_pkg::*;
(
  input  wire logic              clk,   // System clock
  input  wire logic [SYNC_W-1:0] din,   // Raw pin levels
  output logic      [SYNC_W-1:0] dout   // Filtered levels
);
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] lvl;
  } psar_sync_t;

  psar_sync_t sync_q;
  psar_sync_t sync_d;

  always_comb begin
    sync_d    = sync_q;
    sync_d.s1 = din;
    sync_d.s2 = sync_q.s1;
    sync_d.s3 = sync_q.s2;
    // A change counts only once stages two and three agree
    for (int i = 0; i < SYNC_W; i++) begin
      if (sync_q.s2[i] == sync_q.s3[i]) begin
        sync_d.lvl[i] = sync_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    sync_q <= sync_d;
  end

  assign dout = sync_q.lvl;
endmodule : psar_sync

// File: testbench/psar_smc_model.sv
// Purpose: Station management controller model driving management frames
// Assumes: Ten clk per mdc bit, five high and five low; wire has a pull-up
// Notes:   mdc stands low between frames; the line is released outside frames
`timescale 1ns/1ns
module psar_smc_model
  import psar_pkg::*;
(
  input  wire logic clk,      // System clock
  input  wire logic mdio,     // Resolved data wire
  output logic      mdc,      // Management clock pin
  output logic      drv_oe,   // Controller drives the wire
  output logic      drv_val   // Level driven by the controller
);
  initial begin
    mdc = 1'b0;
    drv_oe = 1'b0;
    drv_val = 1'b1;
  end

  // Data changes with the falling edge, sampled just before the rise
  task automatic slot(input logic v, input logic drive, output logic smp);
    drv_oe <= drive;
    drv_val <= v;
    repeat (5) @(posedge clk);
    smp = mdio;
    mdc <= 1'b1;
    repeat (5) @(posedge clk);
    mdc <= 1'b0;
  endtask : slot

  // Reads release the wire after the register address; rdat holds TA and data
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [17:0] rdat);
    logic [33:0] bits;
    logic        s;
    bits = {4'b1101, op, pa, ra, 2'b10, wd};
    for (int i = 33; i >= 0; i--) begin
      slot(bits[i], (op != OP_READ) || (i > 17), s);
      if (i <= 17) rdat[i] = s;
    end
    drv_oe <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : frame
endmodule : psar_smc_model

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the port status register bank
// Assumes: Status inputs change on clk; frames come from the controller model
// Notes:   Read results carry both turnaround bits above the data word
`timescale 1ns/1ns
module tb_top
  import psar_pkg::*;
;
  localparam logic [4:0]  PA    = 5'h09;
  localparam logic [15:0] OUI_H = 16'h1357;  // Arbitrary value
  localparam logic [5:0]  OUI_L = 6'h2b;     // Arbitrary value
  localparam logic [5:0]  MODEL = 6'h11;     // Arbitrary value
  localparam logic [3:0]  REV   = 4'h6;      // Arbitrary value
  localparam logic [5:0]  STRAP = 6'h2d;
  localparam logic [15:0] ADV0  = {4'h0, STRAP[5:4], 1'b0, STRAP[3:0], 5'h01};
  logic        clk, srst, mdc, mdio_out, mdio_oe, drv_oe, drv_val, mdio_w;
  logic        an_complete, far_fault, link_up, jabber, link_partner_page_valid;
  logic        parallel_fault, link_partner_np_able, page_received, link_partner_an_able;
  logic [15:0] link_partner_page, advertisement;
  logic [5:0]  strap;
  int          error_cnt, n_checks;

  // Pull-up wins when nobody drives
  assign mdio_w = mdio_oe ? mdio_out : (drv_oe ? drv_val : 1'b1);

  psar_regs #(.ID_OUI_HIGH(OUI_H), .ID_OUI_LOW(OUI_L), .ID_MODEL(MODEL), .ID_REV(REV)) u_dut (
    .clk(clk), .srst(srst), .mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .phy_addr(PA), .config_strap_default(strap),
    .an_complete(an_complete), .far_fault(far_fault), .link_up(link_up), .jabber(jabber),
    .link_partner_page(link_partner_page),
    .link_partner_page_valid(link_partner_page_valid), .parallel_fault(parallel_fault),
    .link_partner_np_able(link_partner_np_able), .page_received(page_received),
    .link_partner_an_able(link_partner_an_able),
    .advertisement(advertisement));

  psar_smc_model u_smc (.clk(clk), .mdio(mdio_w), .mdc(mdc), .drv_oe(drv_oe), .drv_val(drv_val));

  always #20 clk = ~clk;

  task automatic results;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] a,
                      input logic [15:0] d, input logic [17:0] exp);
    logic [17:0] r;
    u_smc.frame(op, pa, a, d, r);
    if (op == OP_READ) check(r, exp);
  endtask : xfer

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    xfer(OP_READ, PA, a, 16'h0000, {2'b10, e});
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    xfer(OP_WRITE, PA, a, d, 18'h00000);
  endtask : wr

  // One-cycle events: far fault, jabber, parallel fault, page, partner load
  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    {far_fault, jabber, parallel_fault, page_received, link_partner_page_valid} <= v;
    @(posedge clk);
    {far_fault, jabber, parallel_fault, page_received, link_partner_page_valid} <= 5'h00;
    repeat (3) @(posedge clk);
  endtask : pulse

  task automatic t_defaults;
    rd(REG_MODE_STATUS, 16'h7949);
    rd(REG_ID_HIGH, OUI_H);
    rd(REG_ID_LOW, {OUI_L, MODEL, REV});
    check({2'b00, advertisement}, {2'b00, ADV0});
    rd(REG_ADVERT, ADV0);
    rd(REG_PARTNER, 16'h0000);
    rd(REG_EXPANSION, 16'h0004);
    rd(5'h07, 16'h0000);
    xfer(OP_READ, PA ^ 5'h01, REG_ID_HIGH, 16'h0000, 18'h3ffff);
  endtask : t_defaults

  task automatic t_status;
    @(posedge clk);
    {an_complete, link_up} <= 2'b11;
    pulse(5'b11000);
    rd(REG_MODE_STATUS, 16'h797b);
    rd(REG_MODE_STATUS, 16'h796d);
    @(posedge clk);
    link_up <= 1'b0;
    @(posedge clk);
    link_up <= 1'b1;
    rd(REG_MODE_STATUS, 16'h7969);
    rd(REG_MODE_STATUS, 16'h796d);
  endtask : t_status

  task automatic t_expansion;
    @(posedge clk);
    {link_partner_np_able, link_partner_an_able} <= 2'b11;
    pulse(5'b00110);
    rd(REG_EXPANSION, 16'h001f);
    rd(REG_EXPANSION, 16'h000d);
    @(posedge clk);
    {link_partner_np_able, link_partner_an_able} <= 2'b00;
    rd(REG_EXPANSION, 16'h0004);
  endtask : t_expansion

  task automatic t_partner;
    @(posedge clk);
    link_partner_page <= 16'hffff;
    pulse(5'b00001);
    rd(REG_PARTNER, 16'hefff);
    wr(REG_PARTNER, 16'h0000);
    rd(REG_PARTNER, 16'hefff);
    link_partner_page <= 16'h0c21;
    pulse(5'b00001);
    rd(REG_PARTNER, 16'h0c21);
  endtask : t_partner

  task automatic t_writes;
    wr(REG_ADVERT, 16'hffff);
    check({2'b00, advertisement}, 18'h0bfff);
    rd(REG_ADVERT, 16'hbfff);
    wr(REG_ADVERT, 16'h0000);
    xfer(2'b11, PA, REG_ADVERT, 16'h5555, 18'h00000);
    xfer(OP_WRITE, PA ^ 5'h01, REG_ADVERT, 16'hffff, 18'h00000);
    rd(REG_ADVERT, 16'h0000);
    wr(REG_MODE_STATUS, 16'h0000);
    rd(REG_MODE_STATUS, 16'h796d);
    wr(REG_ID_HIGH, 16'h0000);
    rd(REG_ID_HIGH, OUI_H);
    // Mid-run reset must bring the strap defaults back
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    check({2'b00, advertisement}, {2'b00, ADV0});
    rd(REG_MODE_STATUS, 16'h7969);
  endtask : t_writes

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {an_complete, far_fault, link_up, jabber, link_partner_page_valid} = 5'h00;
    {parallel_fault, link_partner_np_able, page_received, link_partner_an_able} = 4'h0;
    link_partner_page = 16'h0000;
    strap = STRAP;
    error_cnt = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_defaults();
    t_status();
    t_expansion();
    t_partner();
    t_writes();
    results();
  end

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule : tb_top
